//--- cpsp_ahb_front.sv
`timescale 1ns/1ps
`include "cpsp_cfg.svh"

module cpsp_ahb_front (
  input  wire logic             mclk_in,        // core clock
  input  wire logic             resetn_in,      // sync reset, low
  input  wire logic             hsel_in,        // slave select
  input  wire logic [31:0]      haddr_in,       // byte address
  input  wire logic [1:0]       htrans_in,      // transfer type
  input  wire logic             hwrite_in,      // write when high
  input  wire logic             hready_in,      // bus ready
  input  wire logic [31:0]      rd_word_in,     // bank read mux
  output cpsp_pkg::cpsp_acc_s   acc_out,        // access to bank
  output logic                  hreadyout_out,  // slave ready
  output logic [31:0]           hrdata_out      // registered read data
);

  cpsp_pkg::cpsp_bus_e state;
  cpsp_pkg::cpsp_bus_e next_state;
  logic [31:0]         next_rdata;
  logic [3:0]          idx;
  logic [3:0]          next_idx;
  logic                mapped;
  logic                next_mapped;
  logic                take;

  // reads take one wait cycle so that read data comes from a flop
  assign take = hready_in && hsel_in && htrans_in[1] && (state != cpsp_pkg::CPSP_RWAIT);

  always_comb begin
    next_state  = state;
    next_idx    = idx;
    next_mapped = mapped;
    next_rdata  = hrdata_out;
    if (state == cpsp_pkg::CPSP_RWAIT) begin
      next_state = cpsp_pkg::CPSP_RDONE;
      next_rdata = rd_word_in;
    end else if (take) begin
      next_state  = hwrite_in ? cpsp_pkg::CPSP_WDATA : cpsp_pkg::CPSP_RWAIT;
      next_idx    = haddr_in[`CPSP_ADDR_IDX_HI:`CPSP_ADDR_IDX_LO];
      next_mapped = (haddr_in[31:`CPSP_ADDR_PAGE_LO] == '0) &&
                    (haddr_in[`CPSP_ADDR_IDX_HI:`CPSP_ADDR_IDX_LO] <= `CPSP_IDX_LAST);
    end else if (hready_in) begin
      next_state = cpsp_pkg::CPSP_IDLE;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state      <= cpsp_pkg::CPSP_IDLE;
      idx        <= 4'h0;
      mapped     <= 1'b0;
      hrdata_out <= 32'h0;
    end else begin
      state      <= next_state;
      idx        <= next_idx;
      mapped     <= next_mapped;
      hrdata_out <= next_rdata;
    end
  end

  assign hreadyout_out = (state != cpsp_pkg::CPSP_RWAIT);
  assign acc_out.wr     = (state == cpsp_pkg::CPSP_WDATA);
  assign acc_out.rd     = (state == cpsp_pkg::CPSP_RWAIT);
  assign acc_out.mapped = mapped;
  assign acc_out.idx    = idx;

endmodule

//--- cpsp_cfg.svh
`ifndef CPSP_CFG_SVH
`define CPSP_CFG_SVH

// register indices; byte address is index times four
`define CPSP_IDX_POWER       4'h0
`define CPSP_IDX_STATUS      4'h1
`define CPSP_IDX_MOD_FIRST   4'h2
`define CPSP_IDX_LAST        4'h9
`define CPSP_IDX_W           4

// byte address fields
`define CPSP_ADDR_IDX_HI     5
`define CPSP_ADDR_IDX_LO     2
`define CPSP_ADDR_PAGE_LO    6

// power control field positions
`define CPSP_POWER_AUX_OFF   7
`define CPSP_POWER_QUIET     6
`define CPSP_POWER_FLAG_HI   3
`define CPSP_POWER_FLAG_LO   2
`define CPSP_POWER_DOWN      1
`define CPSP_POWER_IDLE      0

// status word field positions
`define CPSP_STATUS_CARRY    7
`define CPSP_STATUS_AUX_CY   6
`define CPSP_STATUS_USER     5
`define CPSP_STATUS_BANK_HI  4
`define CPSP_STATUS_BANK_LO  3
`define CPSP_STATUS_OVERFLOW 2
`define CPSP_STATUS_PARITY   0

// modulator control field positions
`define CPSP_MOD_ENABLE      7
`define CPSP_MOD_HIGH_HI     5
`define CPSP_MOD_KEEP_MASK   8'hBF

// reset values
`define CPSP_POWER_RST       8'h00
`define CPSP_STATUS_RST      8'h00
`define CPSP_MOD_RST         8'h00

// misc sizes
`define CPSP_AUX_TOP         16'h0100
`define CPSP_STEP_FIRST      6'h00
`define CPSP_STEP_INC        6'h01
`define CPSP_STEP_LAST       6'h3F
`define CPSP_NUM_CH          8

`endif

//--- cpsp_core_regs.sv
// Contract
// - aux ram disable set: every external data move goes to external memory.
// - quiet bit set: address latch strobe stays low during internal accesses.
// - writing one to powerdown_activate enters power-down mode.
// - writing one to idle_activate enters idle mode.
// - user_flag_zero is stored and read back, with no side effect.
// - working_bank_select maps R0-to 00H, 08H, 10H or 18H upward.
// - each of eight modulator channels runs only while its enable is one.
// - each channel takes its high time from a six-bit field.
`timescale 1ns/1ps
`include "cpsp_cfg.svh"

module cpsp_core_regs (
  input  wire logic        mclk_in,             // core clock, 50 MHz
  input  wire logic        resetn_in,           // sync reset, low
  input  wire logic        hsel_in,             // bus slave select
  input  wire logic [31:0] haddr_in,            // bus byte address
  input  wire logic [1:0]  htrans_in,           // bus transfer type
  input  wire logic        hwrite_in,           // bus write
  input  wire logic [2:0]  hsize_in,            // bus size, word only
  input  wire logic [31:0] hwdata_in,           // bus write data
  input  wire logic        hready_in,           // bus ready
  output logic             hreadyout_out,       // slave ready
  output logic             hresp_out,           // always okay
  output logic [31:0]      hrdata_out,          // bus read data
  input  wire logic        xdata_req_in,        // external data move request
  input  wire logic [15:0] xdata_addr_in,       // its address
  output logic             xdata_ext_sel_out,   // go to external memory
  output logic             xdata_aux_sel_out,   // go to aux ram
  input  wire logic        ale_raw_in,          // core strobe before gating
  input  wire logic        access_internal_in,  // current fetch is internal
  output logic             ale_out,             // gated latch strobe
  input  wire logic        wake_in,             // wake event from core
  output logic             powerdown_out,       // power-down mode
  output logic             idle_out,            // idle mode
  input  wire logic        flag_load_in,        // alu flag update
  input  wire logic        carry_in,            // new carry
  input  wire logic        aux_carry_in,        // new aux carry
  input  wire logic        overflow_in,         // new overflow
  input  wire logic [7:0]  acc_in,              // accumulator for parity
  input  wire logic [2:0]  work_reg_in,         // working register number
  output logic [4:0]       bank_base_out,       // bank start address
  output logic [4:0]       work_addr_out,       // ram address of register
  output logic [7:0]       pwm_out              // modulator outputs
);

  cpsp_pkg::cpsp_acc_s   acc;
  cpsp_pkg::cpsp_power_s power;
  cpsp_pkg::cpsp_power_s next_power;
  logic [7:0]            status;
  logic [7:0]            next_status;
  logic [7:0]            pwm_reg [`CPSP_NUM_CH];
  logic [7:0]            next_pwm_reg [`CPSP_NUM_CH];
  logic [7:0]            mod_en;
  logic [5:0]            step;
  logic [5:0]            next_step;
  logic                  next_ext;
  logic                  next_aux;
  logic                  next_ale;
  logic [4:0]            next_work_addr;
  logic [31:0]           rd_word;
  logic                  wr_power;
  logic                  wr_status;
  logic [7:0]            wbyte;
  logic [7:0]            power_byte;
  logic [7:0]            status_byte;

  // only word transfers are expected; size is not checked
  cpsp_ahb_front u_front (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hready_in     (hready_in),
    .rd_word_in    (rd_word),
    .acc_out       (acc),
    .hreadyout_out (hreadyout_out),
    .hrdata_out    (hrdata_out)
  );

  // write strobes; only the low byte of each word carries bits
  assign hresp_out = 1'b0;
  assign wbyte     = hwdata_in[7:0];
  assign wr_power  = acc.wr && acc.mapped && (acc.idx == `CPSP_IDX_POWER);
  assign wr_status = acc.wr && acc.mapped && (acc.idx == `CPSP_IDX_STATUS);

  // packed views for readback; unused power control positions read zero
  always_comb begin
    power_byte = 8'h00;
    power_byte[`CPSP_POWER_AUX_OFF] = power.aux_off;
    power_byte[`CPSP_POWER_QUIET]   = power.quiet;
    power_byte[`CPSP_POWER_FLAG_HI] = power.flag_hi;
    power_byte[`CPSP_POWER_FLAG_LO] = power.flag_lo;
    power_byte[`CPSP_POWER_DOWN]    = power.down;
    power_byte[`CPSP_POWER_IDLE]    = power.idle;
    status_byte = status;
    status_byte[`CPSP_STATUS_PARITY] = ^acc_in;  // parity follows the accumulator, read only
  end

  // power control: a write of one beats a same-cycle wake
  always_comb begin
    next_power = power;
    if (wake_in) begin
      next_power.down = 1'b0;
      next_power.idle = 1'b0;
    end
    if (wr_power) begin
      next_power.aux_off = wbyte[`CPSP_POWER_AUX_OFF];
      next_power.quiet   = wbyte[`CPSP_POWER_QUIET];
      next_power.flag_hi = wbyte[`CPSP_POWER_FLAG_HI];
      next_power.flag_lo = wbyte[`CPSP_POWER_FLAG_LO];
      // a zero write leaves a mode alone; only wake ends it
      if (wbyte[`CPSP_POWER_DOWN]) begin
        next_power.down = 1'b1;
      end
      if (wbyte[`CPSP_POWER_IDLE]) begin
        next_power.idle = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      power <= cpsp_pkg::cpsp_power_s'(`CPSP_POWER_RST);
    end else begin
      power <= next_power;
    end
  end

  // mode levels go straight out of the flops, so they never glitch
  assign powerdown_out = power.down;
  assign idle_out      = power.idle;

  // status word: an alu flag update wins over a software write of the same flags
  always_comb begin
    next_status = status;
    if (wr_status) begin
      next_status = wbyte;
    end
    if (flag_load_in) begin
      next_status[`CPSP_STATUS_CARRY]    = carry_in;
      next_status[`CPSP_STATUS_AUX_CY]   = aux_carry_in;
      next_status[`CPSP_STATUS_OVERFLOW] = overflow_in;
    end
    // parity is never stored; the read view computes it live
    next_status[`CPSP_STATUS_PARITY] = 1'b0;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      status <= `CPSP_STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // bank base is the select field times eight
  assign bank_base_out = {status[`CPSP_STATUS_BANK_HI:`CPSP_STATUS_BANK_LO], 3'h0};

  // modulator control registers, one word each
  genvar gi;
  generate
    for (gi = 0; gi < `CPSP_NUM_CH; gi++) begin : g_ch
      always_comb begin
        next_pwm_reg[gi] = pwm_reg[gi];
        if (acc.wr && acc.mapped && (acc.idx == (`CPSP_IDX_MOD_FIRST + 4'(gi)))) begin
          next_pwm_reg[gi] = wbyte & `CPSP_MOD_KEEP_MASK;  // spare bit reads zero
        end
      end

      always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
          pwm_reg[gi] <= `CPSP_MOD_RST;
        end else begin
          pwm_reg[gi] <= next_pwm_reg[gi];
        end
      end

      assign mod_en[gi] = pwm_reg[gi][`CPSP_MOD_ENABLE];

      cpsp_pwm_channel u_ch (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .enable_in (mod_en[gi]),
        .high_in   (pwm_reg[gi][`CPSP_MOD_HIGH_HI:0]),
        .step_in   (step),
        .pwm_out   (pwm_out[gi])
      );
    end
  endgenerate

  // one shared step counter keeps all channels phase aligned
  // trade-off: a new high time takes effect mid-period, not at the wrap
  always_comb begin
    next_step = (step == `CPSP_STEP_LAST) ? `CPSP_STEP_FIRST : step + `CPSP_STEP_INC;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      step <= `CPSP_STEP_FIRST;
    end else begin
      step <= next_step;
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_word = 32'h0;
    if (acc.mapped) begin
      if (acc.idx == `CPSP_IDX_POWER) begin
        rd_word = {24'h0, power_byte};
      end else if (acc.idx == `CPSP_IDX_STATUS) begin
        rd_word = {24'h0, status_byte};
      end else begin
        rd_word = {24'h0, pwm_reg[3'(acc.idx - `CPSP_IDX_MOD_FIRST)]};
      end
    end
  end

  // memory side selects, strobe gating and register address, registered
  always_comb begin
    next_ext = xdata_req_in && (power.aux_off || (xdata_addr_in >= `CPSP_AUX_TOP));
    next_aux = xdata_req_in && !power.aux_off && (xdata_addr_in < `CPSP_AUX_TOP);
    next_ale = ale_raw_in && !(power.quiet && access_internal_in);
    next_work_addr = {status[`CPSP_STATUS_BANK_HI:`CPSP_STATUS_BANK_LO], work_reg_in};
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      xdata_ext_sel_out <= 1'b0;
      xdata_aux_sel_out <= 1'b0;
      ale_out           <= 1'b0;
      work_addr_out     <= '0;
    end else begin
      xdata_ext_sel_out <= next_ext;
      xdata_aux_sel_out <= next_aux;
      ale_out           <= next_ale;
      work_addr_out     <= next_work_addr;
    end
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // memory routing and strobe gating
  AST_AUX_ROUTE: assert property (xdata_req_in && power.aux_off |=> xdata_ext_sel_out && !xdata_aux_sel_out)
    else $error("external data move reached aux ram while disabled");
  AST_AUX_ALLOW: assert property (xdata_req_in && !power.aux_off && (xdata_addr_in < `CPSP_AUX_TOP)
                                  |=> xdata_aux_sel_out && !xdata_ext_sel_out)
    else $error("low data move missed aux ram while enabled");
  AST_NO_REQ: assert property (!xdata_req_in |=> !xdata_ext_sel_out && !xdata_aux_sel_out)
    else $error("memory select without a request");
  AST_ALE_QUIET: assert property (power.quiet && access_internal_in |=> !ale_out)
    else $error("strobe toggled during internal access");
  AST_ALE_PASS: assert property (ale_raw_in && !(power.quiet && access_internal_in) |=> ale_out)
    else $error("strobe lost outside a quiet internal access");

  // mode entry, holding and exit
  AST_PD_SET: assert property (wr_power && wbyte[`CPSP_POWER_DOWN] |=> powerdown_out)
    else $error("power-down not entered after write");
  AST_PD_HOLD: assert property (powerdown_out && !wake_in |=> powerdown_out)
    else $error("power-down left without wake");
  AST_IDLE_SET: assert property (wr_power && wbyte[`CPSP_POWER_IDLE] |=> idle_out ##1 (idle_out || $past(wake_in)))
    else $error("idle not entered after write");
  AST_IDLE_HOLD: assert property (idle_out && !wake_in |=> idle_out)
    else $error("idle left without wake");
  AST_WAKE_CLEAR: assert property (wake_in && !wr_power |=> !powerdown_out && !idle_out)
    else $error("mode kept after wake");

  // status word
  AST_FLAG_KEEP: assert property (!wr_status |=> $stable(status[`CPSP_STATUS_USER]))
    else $error("user flag changed without a write");
  AST_FLAG_WRITE: assert property (wr_status |=> status[`CPSP_STATUS_USER] == $past(wbyte[`CPSP_STATUS_USER]))
    else $error("user flag did not take the written value");
  AST_BANK_MAP: assert property (wr_status && !flag_load_in
                                 |=> bank_base_out == {$past(wbyte[`CPSP_STATUS_BANK_HI:`CPSP_STATUS_BANK_LO]), 3'h0})
    else $error("bank base does not follow select");
  AST_WORK_ADDR: assert property (1'b1 |=> work_addr_out == {$past(bank_base_out[4:3]), $past(work_reg_in)})
    else $error("working register address outside its bank");

  // modulator channels
  AST_PWM_OFF: assert property (!mod_en[0] |=> !pwm_out[0])
    else $error("disabled channel drives high");
  AST_PWM_OFF_ALL: assert property (1'b1 |=> (pwm_out & ~$past(mod_en)) == 8'h00)
    else $error("a disabled channel drives high");
  AST_PWM_HIGH: assert property (mod_en[0] && (step < pwm_reg[0][`CPSP_MOD_HIGH_HI:0]) |=> pwm_out[0])
    else $error("channel low inside its high time");
  AST_PWM_LOW: assert property (step >= pwm_reg[0][`CPSP_MOD_HIGH_HI:0] |=> !pwm_out[0])
    else $error("channel high outside its high time");
  AST_PWM_PERIOD: assert property (step == `CPSP_STEP_LAST |=> step == `CPSP_STEP_FIRST ##1 step == `CPSP_STEP_INC)
    else $error("period step did not wrap");
  AST_STEP_ADV: assert property (step != `CPSP_STEP_LAST |=> step == $past(step) + `CPSP_STEP_INC)
    else $error("period step skipped");

  // main scenarios
  COV_POWERDOWN: cover property (wr_power && wbyte[`CPSP_POWER_DOWN] ##1 powerdown_out ##[1:20] !powerdown_out);
  COV_PWM: cover property (mod_en[3] && pwm_out[3] ##1 !pwm_out[3]);
  COV_READ: cover property (acc.rd && acc.idx == `CPSP_IDX_STATUS ##1 hreadyout_out);
  COV_AUX: cover property (xdata_req_in && !power.aux_off ##1 xdata_aux_sel_out);

endmodule

//--- cpsp_pkg.sv
package cpsp_pkg;

  // slave state of the bus front end
  typedef enum logic [1:0] {
    CPSP_IDLE,
    CPSP_WDATA,
    CPSP_RWAIT,
    CPSP_RDONE
  } cpsp_bus_e;

  // one register access, handed from the bus front end to the bank
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       mapped;
    logic [3:0] idx;
  } cpsp_acc_s;

  // working copy of the power control bits
  typedef struct packed {
    logic aux_off;
    logic quiet;
    logic flag_hi;
    logic flag_lo;
    logic down;
    logic idle;
  } cpsp_power_s;

endpackage

//--- cpsp_pwm_channel.sv
`timescale 1ns/1ps
`include "cpsp_cfg.svh"

module cpsp_pwm_channel (
  input  wire logic       mclk_in,    // core clock
  input  wire logic       resetn_in,  // sync reset, low
  input  wire logic       enable_in,  // channel enable
  input  wire logic [5:0] high_in,    // high time in steps
  input  wire logic [5:0] step_in,    // shared period step
  output logic            pwm_out     // registered output
);

  logic next_pwm;

  // high while the step is below the high time; low when disabled
  always_comb begin
    next_pwm = enable_in && (step_in < high_in);
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_pwm;
    end
  end

endmodule

//--- test_core_power_status_pwm_regs.sv
`timescale 1ns/1ps

module test_core_power_status_pwm_regs;
  // every input is driven by the bench, changed right after a rising edge
  logic        mclk_in, resetn_in, hsel, hwrite, xreq, ale_raw, a_int, wake;
  logic        hready, hresp, ext_sel, aux_sel, ale, pdown, idle;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [15:0] xaddr, a16;
  logic [7:0]  acc, pwm, sw;
  logic [2:0]  wreg;
  logic [4:0]  bbase, waddr;
  logic [7:0]  mod [8];
  logic [6:0]  cnt [8];
  logic [31:0] seed = 32'h00011428;  // 70696
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;

  // alu flag loading is outside this bench, so its inputs stay quiet
  cpsp_core_regs uut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .xdata_req_in(xreq), .xdata_addr_in(xaddr),
    .xdata_ext_sel_out(ext_sel), .xdata_aux_sel_out(aux_sel), .ale_raw_in(ale_raw),
    .access_internal_in(a_int), .ale_out(ale), .wake_in(wake), .powerdown_out(pdown), .idle_out(idle),
    .flag_load_in(1'h0), .carry_in(1'h0), .aux_carry_in(1'h0), .overflow_in(1'h0), .acc_in(acc),
    .work_reg_in(wreg), .bank_base_out(bbase), .work_addr_out(waddr), .pwm_out(pwm));

  // clock, 20 ns period
  initial begin
    mclk_in = 1'h0;
    forever #10 mclk_in = ~mclk_in;
  end

  // hang guard, well beyond the few hundred cycles the run needs
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expectations, worked out from the register layout
  function automatic logic [7:0] exp_mod_rd(input logic [7:0] v);
    return {v[7], 1'h0, v[5:0]};
  endfunction
  function automatic logic [6:0] exp_high(input logic [7:0] v);
    return v[7] ? {1'h0, v[5:0]} : 7'h00;
  endfunction
  function automatic logic exp_ext(input logic dis, input logic [15:0] a);
    return dis | (a >= 16'h0100);
  endfunction
  function automatic logic exp_ale(input logic q, input logic r, input logic i);
    return r & ~(q & i);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // looking at the falling edge shows what the next rising edge samples
  task automatic wait_rdy();
    do @(negedge mclk_in); while (hready !== 1'h1);
  endtask

  // one single word transfer; returns at the falling edge before its last edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] v, output logic [31:0] q);
    @(posedge mclk_in);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    @(posedge mclk_in);
    htrans <= 2'h0;
    hwdata <= {24'h000000, v};
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic [31:0] q;
    bus(1'h1, a, v, q);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 8'h00, q);
    chk(what, {24'h000000, e}, q);
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {hsel, hwrite, xreq, ale_raw, a_int, wake, resetn_in} = 7'h00;
    {htrans, haddr, hwdata, xaddr, acc, wreg} = 93'h0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'h1;
    // all ten registers and one unmapped word read zero after reset
    for (int i = 0; i < 11; i++) rd_chk("reset value", 4 * i, 8'h00);
    chk("outputs after reset", 32'h0, {hresp, pwm, pdown, idle, ext_sel, aux_sel});
    // corner high times first (0, 63, disabled), then fully random ones
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8; i++) begin
        d = xorshift();
        mod[i] = (r == 0 && i < 3) ? ((i == 0) ? 8'h80 : (i == 1) ? 8'hBF : 8'h3F) : d[7:0];
        wr(32'h8 + 4 * i, mod[i]);
      end
      for (int i = 0; i < 8; i++) rd_chk("modulator control", 32'h8 + 4 * i, exp_mod_rd(mod[i]));
      // any 64 consecutive steps hold one full period whatever the phase
      for (int i = 0; i < 8; i++) cnt[i] = 7'h00;
      repeat (64) begin
        @(negedge mclk_in);
        for (int i = 0; i < 8; i++) cnt[i] += {6'h00, pwm[i]};
      end
      for (int i = 0; i < 8; i++) chk("modulator high steps", exp_high(mod[i]), cnt[i]);
    end
    // an unmapped write must not land in the last channel
    wr(32'h28, 8'hFF);
    rd_chk("unmapped word", 32'h28, 8'h00);
    rd_chk("last channel", 32'h24, exp_mod_rd(mod[7]));
    d = xorshift() & 32'hFC;
    wr(32'h0, d[7:0]);
    rd_chk("power control", 32'h0, d[7:0] & 8'hCC);
    // each mode is set by a one, survives a zero write, ends on wake
    for (int m = 0; m < 2; m++) begin
      wr(32'h0, m ? 8'h01 : 8'h02);
      repeat (2) @(negedge mclk_in);
      chk("mode after set", m ? 32'h1 : 32'h2, {pdown, idle});
      wr(32'h0, 8'h00);
      repeat (2) @(negedge mclk_in);
      chk("mode after zero write", m ? 32'h1 : 32'h2, {pdown, idle});
      @(posedge mclk_in);
      wake <= 1'h1;
      @(posedge mclk_in);
      wake <= 1'h0;
      repeat (2) @(negedge mclk_in);
      chk("mode after wake", 32'h0, {pdown, idle});
    end
    // data moves on both sides of the aux ram top, with and without disable
    for (int i = 0; i < 8; i++) begin
      d = xorshift();
      a16 = (i % 4 == 0) ? 16'h00FF : (i % 4 == 1) ? 16'h0100 : (i % 4 == 2) ? {8'h00, d[7:0]} : d[15:0] | 16'h0100;
      wr(32'h0, {i[2], 7'h00});
      @(posedge mclk_in);
      xreq <= 1'h1;
      xaddr <= a16;
      @(posedge mclk_in);
      xreq <= 1'h0;
      @(negedge mclk_in);
      chk("external select", exp_ext(i[2], a16), ext_sel);
      chk("aux select", !exp_ext(i[2], a16), aux_sel);
    end
    // latch strobe for each quiet setting, raw level and access kind
    for (int i = 0; i < 8; i++) begin
      wr(32'h0, {1'h0, i[2], 6'h00});
      @(posedge mclk_in);
      ale_raw <= i[0];
      a_int <= i[1];
      @(posedge mclk_in);
      {ale_raw, a_int} <= 2'h0;
      @(negedge mclk_in);
      chk("latch strobe", exp_ale(i[2], i[0], i[1]), ale);
    end
    // every bank, with random flag bits, accumulator and register number
    for (int b = 0; b < 4; b++) begin
      d = xorshift();
      sw = {d[7:5], b[1:0], d[2:1], 1'h0};
      @(posedge mclk_in);
      acc <= d[15:8];
      wreg <= d[18:16];
      wr(32'h4, sw);
      rd_chk("status word", 32'h4, {sw[7:1], ^d[15:8]});
      chk("bank base", {b[1:0], 3'h0}, bbase);
      chk("working address", {b[1:0], d[18:16]}, waddr);
    end
    end_of_test();
  end
endmodule
